// File: design/cpbi_pkg.sv
// Shared constants and types of the coprocessor host bus interface.
package cpbi_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CPBI_CLK_MHZ = 250;
	localparam int CPBI_PULLUP_TIME_NS = 8;
	localparam int CPBI_PULLUP_CYC_RAW = (CPBI_PULLUP_TIME_NS * CPBI_CLK_MHZ + 999) / 1000;
	localparam int CPBI_PULLUP_CYC = (CPBI_PULLUP_CYC_RAW < 1) ? 1 : CPBI_PULLUP_CYC_RAW;
	localparam int CPBI_CNT_W = 4;
	localparam logic [CPBI_CNT_W-1:0] CPBI_PULLUP_LAST = CPBI_CNT_W'(CPBI_PULLUP_CYC - 1);

	// ----------------------------------------------------------------
	// Data lane layout
	// ----------------------------------------------------------------
	localparam logic [3:0] CPBI_LANES_ALL = 4'hF;
	localparam logic [3:0] CPBI_LANES_UPPER_HALF = 4'hC;
	localparam logic [3:0] CPBI_LANES_TOP_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Floating-point state layout and reset values
	// ----------------------------------------------------------------
	localparam int CPBI_FP_REGS = 8;
	localparam int CPBI_FP_W = 80;
	localparam logic [CPBI_FP_W-1:0] CPBI_FP_QNAN = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;
	localparam logic [3:0] CPBI_SEL_CTRL = 4'h8;
	localparam logic [3:0] CPBI_SEL_STATUS = 4'h9;
	localparam logic [3:0] CPBI_SEL_IADDR = 4'hA;

	typedef enum logic [1:0] {CPBI_MODE_8, CPBI_MODE_16, CPBI_MODE_32} cpbi_mode_e;
	typedef enum logic [2:0] {ST_IDLE, ST_SKIP, ST_WAIT_DATA, ST_REQ, ST_ACK, ST_PULLUP} cpbi_state_e;

	typedef struct packed {
		logic [CPBI_FP_REGS-1:0][CPBI_FP_W-1:0] data;
		logic [31:0] ctrl;
		logic [31:0] status;
		logic [31:0] iaddr;
		logic [CPBI_FP_W-1:0] rd;
	} cpbi_fp_s;

	localparam cpbi_fp_s CPBI_FP_RST = '{
		data: {CPBI_FP_REGS{CPBI_FP_QNAN}},
		ctrl: 32'h0000_0000,
		status: 32'h0000_0000,
		iaddr: 32'h0000_0000,
		rd: 80'h0
	};

endpackage

// File: design/cpbi_fp_state.sv
// Floating-point register state with its reset initialisation.
`timescale 1ns/10ps
`default_nettype none
module cpbi_fp_state
	import cpbi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [3:0] wr_sel,
	input wire logic [CPBI_FP_W-1:0] wr_data,
	input wire logic [3:0] rd_sel,
	output logic [CPBI_FP_W-1:0] rd_data
);

	cpbi_fp_s q, d;

	always_comb begin
		d = q;
		if (wr_en) begin
			if (wr_sel == CPBI_SEL_CTRL) begin
				d.ctrl = wr_data[31:0];
			end else if (wr_sel == CPBI_SEL_STATUS) begin
				d.status = wr_data[31:0];
			end else if (wr_sel == CPBI_SEL_IADDR) begin
				d.iaddr = wr_data[31:0];
			end else if (!wr_sel[3]) begin
				d.data[wr_sel[2:0]] = wr_data;
			end
		end
		if (rd_sel == CPBI_SEL_CTRL) begin
			d.rd = {48'h0, q.ctrl};
		end else if (rd_sel == CPBI_SEL_STATUS) begin
			d.rd = {48'h0, q.status};
		end else if (rd_sel == CPBI_SEL_IADDR) begin
			d.rd = {48'h0, q.iaddr};
		end else if (!rd_sel[3]) begin
			d.rd = q.data[rd_sel[2:0]];
		end else begin
			d.rd = 80'h0;
		end
	end

	// Reset loads quiet NaNs and clears control, status and address.
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= CPBI_FP_RST;
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rd;

	chk_fp_reset_init: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> (q.data == {CPBI_FP_REGS{CPBI_FP_QNAN}}) && (q.ctrl == 32'h0)
			&& (q.status == 32'h0) && (q.iaddr == 32'h0))
		else $error("fp state not initialised by reset");

endmodule
`default_nettype wire

// File: design/cpbi_bus_port.sv
// Host bus port of the floating-point coprocessor with acknowledge encoding.
// Summary of operation
// - All host traffic uses ordinary asynchronous strobed bus cycles.
// - Strap high and low address bit high select 32-bit bus.
// - Strap high and low address bit low select 16-bit bus.
// - Strap low selects 8-bit bus regardless of other straps.
// - Direction high means host read, low means host write.
// - On selected read, acknowledge signals read data; both are driven on the same clock.
// - On selected write, acknowledge signals the data was accepted.
// - 32-bit mode, address bit four set: both acknowledges asserted.
// - 32-bit mode, address bit four clear: word acknowledge only, upper half.
// - 16-bit mode: word acknowledge only, byte acknowledge negated.
// - 8-bit mode: byte acknowledge only, word acknowledge never.
// - Both acknowledges negated means wait states; device may delay them.
// - After a strobe rises, drive acknowledges high briefly, then release.
// - Reset loads data registers with quiet NaN, clears control registers.
// - Five low address inputs select the interface register.
// - In 8-bit mode the low address bit is a live byte select.
`timescale 1ns/10ps
`default_nettype none
module cpbi_bus_port
	import cpbi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic chip_select_n,
	input wire logic read_write,
	input wire logic width_strap_n,
	input wire logic low_address_bit,
	input wire logic address_bit_four,
	input wire logic [2:0] address_mid,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic [3:0] data_oe,
	output logic byte_port_acknowledge_n,
	output logic byte_port_acknowledge_oe,
	output logic word_port_acknowledge_n,
	output logic word_port_acknowledge_oe,
	output logic [4:0] reg_select,
	output logic reg_request,
	output logic reg_write,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_ready,
	output logic [1:0] bus_mode,
	input wire logic fp_wr_en,
	input wire logic [3:0] fp_wr_sel,
	input wire logic [CPBI_FP_W-1:0] fp_wr_data,
	input wire logic [3:0] fp_rd_sel,
	output logic [CPBI_FP_W-1:0] fp_rd_data
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Pin synchronisers hold stage 0 in bit 0 and stage 1 in bit 1.
	// Strobes and chip select are stored asserted-high.
	typedef struct packed {
		logic [1:0] as_on;
		logic [1:0] dstb_on;
		logic [1:0] cs_on;
		logic [1:0] rw;
		logic [1:0] strap;
		logic [1:0] lsb;
		logic [1:0][3:0] addr;
		logic [1:0][31:0] din;
		cpbi_mode_e mode;
		cpbi_state_e st;
		logic dstb_seen;
		logic [4:0] sel;
		logic wr;
		logic req;
		logic [31:0] wdata;
		logic [31:0] dout;
		logic [3:0] doe;
		logic bk_on;
		logic bk_oe;
		logic wk_on;
		logic wk_oe;
		logic [CPBI_CNT_W-1:0] cnt;
	} cpbi_port_s;

	cpbi_port_s q, d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.req = 1'b0;
		d.as_on = {q.as_on[0], ~address_strobe_n};
		d.dstb_on = {q.dstb_on[0], ~data_strobe_n};
		d.cs_on = {q.cs_on[0], ~chip_select_n};
		d.rw = {q.rw[0], read_write};
		d.strap = {q.strap[0], width_strap_n};
		d.lsb = {q.lsb[0], low_address_bit};
		d.addr = {q.addr[0], {address_bit_four, address_mid}};
		d.din = {q.din[0], data_in};

		if (!q.strap[1]) begin
			d.mode = CPBI_MODE_8;
		end else if (q.lsb[1]) begin
			d.mode = CPBI_MODE_32;
		end else begin
			d.mode = CPBI_MODE_16;
		end

		case (q.st)
			ST_IDLE: begin
				d.dstb_seen = 1'b0;
				if (q.as_on[1]) begin
					// The host guarantees select, direction and address are settled here.
					if (q.cs_on[1]) begin
						d.sel = {q.addr[1], q.lsb[1]};
						d.wr = ~q.rw[1];
						if (q.rw[1]) begin
							d.req = 1'b1;
							d.st = ST_REQ;
						end else begin
							d.st = ST_WAIT_DATA;
						end
					end else begin
						d.st = ST_SKIP;
					end
				end
			end
			ST_SKIP: begin
				if (!q.as_on[1]) begin
					d.st = ST_IDLE;
				end
			end
			ST_WAIT_DATA: begin
				if (!q.as_on[1]) begin
					d.st = ST_IDLE;
				end else if (q.dstb_on[1]) begin
					d.dstb_seen = 1'b1;
					d.wdata = q.din[1];
					d.req = 1'b1;
					d.st = ST_REQ;
				end
			end
			ST_REQ: begin
				// Acknowledges stay negated here, which stretches the host cycle.
				d.dstb_seen = q.dstb_seen | q.dstb_on[1];
				if (!q.as_on[1]) begin
					d.st = ST_IDLE;
				end else if (reg_ready) begin
					d.st = ST_ACK;
					d.bk_oe = 1'b1;
					d.wk_oe = 1'b1;
					case (q.mode)
						CPBI_MODE_32: begin
							d.bk_on = q.sel[4];
							d.wk_on = 1'b1;
						end
						CPBI_MODE_16: begin
							d.bk_on = 1'b0;
							d.wk_on = 1'b1;
						end
						default: begin
							d.bk_on = 1'b1;
							d.wk_on = 1'b0;
						end
					endcase
					if (!q.wr) begin
						// Sixteen-bit registers always sit on the upper data half.
						case (q.mode)
							CPBI_MODE_32: begin
								d.dout = q.sel[4] ? reg_rdata : {reg_rdata[15:0], 16'h0000};
								d.doe = q.sel[4] ? CPBI_LANES_ALL : CPBI_LANES_UPPER_HALF;
							end
							CPBI_MODE_16: begin
								d.dout = {reg_rdata[15:0], 16'h0000};
								d.doe = CPBI_LANES_UPPER_HALF;
							end
							default: begin
								d.dout = {reg_rdata[7:0], 24'h00_0000};
								d.doe = CPBI_LANES_TOP_BYTE;
							end
						endcase
					end
				end
			end
			ST_ACK: begin
				d.dstb_seen = q.dstb_seen | q.dstb_on[1];
				if (!q.as_on[1] || (q.dstb_seen && !q.dstb_on[1])) begin
					d.bk_on = 1'b0;
					d.wk_on = 1'b0;
					d.doe = 4'h0;
					d.cnt = CPBI_PULLUP_LAST;
					d.st = ST_PULLUP;
				end
			end
			ST_PULLUP: begin
				if (q.cnt == '0) begin
					d.bk_oe = 1'b0;
					d.wk_oe = 1'b0;
					d.st = ST_IDLE;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign data_out = q.dout;
	assign data_oe = q.doe;
	assign byte_port_acknowledge_n = ~q.bk_on;
	assign byte_port_acknowledge_oe = q.bk_oe;
	assign word_port_acknowledge_n = ~q.wk_on;
	assign word_port_acknowledge_oe = q.wk_oe;
	assign reg_select = q.sel;
	assign reg_request = q.req;
	assign reg_write = q.wr;
	assign reg_wdata = q.wdata;
	assign bus_mode = q.mode;

	cpbi_fp_state u_fp_state (
		.clk(clk),
		.rst(rst),
		.wr_en(fp_wr_en),
		.wr_sel(fp_wr_sel),
		.wr_data(fp_wr_data),
		.rd_sel(fp_rd_sel),
		.rd_data(fp_rd_data)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ack_end;
		q.st == ST_ACK ##1 q.st == ST_PULLUP;
	endsequence

	sequence s_pull_release;
		(q.bk_oe && q.wk_oe && !q.bk_on && !q.wk_on)[*2] ##1 (!q.bk_oe && !q.wk_oe);
	endsequence

	chk_mode_eight_bit: assert property (!q.strap[1] |=> q.mode == CPBI_MODE_8)
		else $error("strap low did not select 8-bit mode");
	chk_mode_full_width: assert property (q.strap[1] && q.lsb[1]
		|=> q.mode == CPBI_MODE_32)
		else $error("straps high did not select 32-bit mode");
	chk_mode_half_width: assert property (q.strap[1] && !q.lsb[1]
		|=> q.mode == CPBI_MODE_16)
		else $error("strap pattern did not select 16-bit mode");
	chk_read_direction: assert property (q.st == ST_IDLE && q.as_on[1] && q.cs_on[1] && q.rw[1]
		|=> q.req && !q.wr && q.st == ST_REQ)
		else $error("read cycle not issued as read request");
	chk_ack_after_ready: assert property (q.st == ST_REQ && q.as_on[1] && reg_ready
		|=> q.st == ST_ACK && (q.bk_on || q.wk_on) && q.bk_oe && q.wk_oe)
		else $error("acknowledge missing after ready");
	chk_write_accept: assert property (q.st == ST_WAIT_DATA && q.as_on[1] && q.dstb_on[1]
		|=> q.req && q.wr && q.wdata == $past(q.din[1]))
		else $error("write data not taken on data strobe");
	chk_wait_no_ack: assert property (q.st == ST_REQ |-> !q.bk_on && !q.wk_on)
		else $error("acknowledge asserted while waiting");
	chk_ack_full_width: assert property (q.st == ST_ACK && q.mode == CPBI_MODE_32
		|-> q.wk_on && (q.bk_on == q.sel[4]))
		else $error("wrong acknowledge pair in 32-bit mode");
	chk_ack_half_width: assert property (q.st == ST_ACK && q.mode == CPBI_MODE_16
		|-> q.wk_on && !q.bk_on)
		else $error("wrong acknowledge pair in 16-bit mode");
	chk_ack_byte_port: assert property (q.st == ST_ACK && q.mode == CPBI_MODE_8
		|-> q.bk_on && !q.wk_on)
		else $error("wrong acknowledge pair in 8-bit mode");
	chk_pullup_release: assert property (s_ack_end |-> s_pull_release)
		else $error("acknowledge lines not driven high then released");

endmodule
`default_nettype wire

// File: tb/cpbi_host_model.sv
// Host processor model that runs strobed bus cycles against the port.
`timescale 1ns/10ps
`default_nettype none
module cpbi_host_model (
	input wire logic clk,
	output var logic address_strobe_n,
	output var logic data_strobe_n,
	output var logic chip_select_n,
	output var logic read_write,
	output var logic address_bit_four,
	output var logic [2:0] address_mid,
	output var logic [31:0] data_in,
	input wire logic [31:0] data_out,
	input wire logic [3:0] data_oe,
	input wire logic byte_port_acknowledge_n,
	input wire logic byte_port_acknowledge_oe,
	input wire logic word_port_acknowledge_n,
	input wire logic word_port_acknowledge_oe
);
	logic byte_line;
	logic word_line;

	// Released acknowledge lines float up to the holding resistor level.
	assign byte_line = byte_port_acknowledge_oe ? byte_port_acknowledge_n : 1'b1;
	assign word_line = word_port_acknowledge_oe ? word_port_acknowledge_n : 1'b1;

	initial begin
		address_strobe_n = 1'b1;
		data_strobe_n = 1'b1;
		chip_select_n = 1'b1;
		read_write = 1'b1;
		address_bit_four = 1'b0;
		address_mid = 3'h0;
		data_in = 32'h0;
	end

	task automatic run(input logic rd, cs_n, bit_four, input logic [2:0] mid, input logic [31:0] wd,
		input int lim, output logic [1:0] ack, output logic [35:0] rdat, output logic rel_ok,
		output time t_ack);
		int n;
		logic pulled;
		@(negedge clk);
		chip_select_n = cs_n;
		read_write = rd;
		address_bit_four = bit_four;
		address_mid = mid;
		data_in = wd;
		@(negedge clk);
		address_strobe_n = 1'b0;
		if (!rd) begin
			@(negedge clk);
			data_strobe_n = 1'b0;
		end
		n = 0;
		ack = 2'b11;
		// Registered outputs are sampled at the falling edge, where they have settled.
		while (ack === 2'b11 && n < lim) begin
			@(negedge clk);
			ack = {word_line, byte_line};
			n++;
		end
		rdat = {data_oe, data_out};
		t_ack = $time;
		@(negedge clk);
		address_strobe_n = 1'b1;
		data_strobe_n = 1'b1;
		chip_select_n = 1'b1;
		data_in = ~wd;
		pulled = 1'b0;
		repeat (8) begin
			@(negedge clk);
			if (byte_port_acknowledge_oe && word_port_acknowledge_oe && byte_line && word_line)
				pulled = 1'b1;
		end
		rel_ok = pulled && !byte_port_acknowledge_oe && !word_port_acknowledge_oe;
	endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the coprocessor host bus port.
`timescale 1ns/10ps
`default_nettype none
module tb
	import cpbi_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic width_strap_n = 1'b1;
	logic low_address_bit = 1'b1;
	logic reg_ready = 1'b0;
	logic fp_wr_en = 1'b0;
	logic [3:0] fp_wr_sel = 4'h0;
	logic [3:0] fp_rd_sel = 4'h0;
	logic [CPBI_FP_W-1:0] fp_wr_data = '0;
	logic [31:0] reg_rdata = 32'h0;
	logic address_strobe_n, data_strobe_n, chip_select_n, read_write, address_bit_four;
	logic byte_port_acknowledge_n, byte_port_acknowledge_oe, reg_request, reg_write;
	logic word_port_acknowledge_n, word_port_acknowledge_oe;
	logic [2:0] address_mid;
	logic [31:0] data_in, data_out, reg_wdata, wd_r, rv;
	logic [3:0] data_oe;
	logic [4:0] reg_select, sel_r;
	logic [1:0] bus_mode;
	logic [CPBI_FP_W-1:0] fp_rd_data;
	logic wr_r;
	int mismatches = 0;
	int cmp_count = 0;
	int nreq = 0;
	int dly = 0;
	time rdy_t;

	always #2 clk = ~clk;

	cpbi_bus_port u_cpbi_bus_port (.clk, .rst, .address_strobe_n, .data_strobe_n,
		.chip_select_n, .read_write, .width_strap_n, .low_address_bit, .address_bit_four,
		.address_mid, .data_in, .data_out, .data_oe, .byte_port_acknowledge_n,
		.byte_port_acknowledge_oe, .word_port_acknowledge_n, .word_port_acknowledge_oe,
		.reg_select, .reg_request, .reg_write, .reg_wdata, .reg_rdata, .reg_ready, .bus_mode,
		.fp_wr_en, .fp_wr_sel, .fp_wr_data, .fp_rd_sel, .fp_rd_data);

	cpbi_host_model u_host (.clk, .address_strobe_n, .data_strobe_n, .chip_select_n,
		.read_write, .address_bit_four, .address_mid, .data_in, .data_out, .data_oe,
		.byte_port_acknowledge_n, .byte_port_acknowledge_oe, .word_port_acknowledge_n,
		.word_port_acknowledge_oe);

	// User side answers each request after a random number of wait states.
	always @(negedge clk) begin
		reg_ready <= 1'b0;
		reg_rdata <= ~rv;
		if (reg_request === 1'b1) begin
			nreq++;
			sel_r = reg_select;
			wr_r = reg_write;
			wd_r = reg_wdata;
			dly = $urandom % 5 + 1;
		end
		if (dly == 1) begin
			reg_ready <= 1'b1;
			reg_rdata <= rv;
			rdy_t = $time;
		end
		if (dly > 0)
			dly--;
	end

	task automatic cmp_d(input logic [79:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_f(input logic [1:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic fp_check;
		for (int i = 0; i < 11; i++) begin
			@(negedge clk);
			fp_rd_sel = 4'(i);
			@(negedge clk);
			cmp_d(fp_rd_data, (i < 8) ? CPBI_FP_QNAN : '0);
		end
	endtask

	task automatic bus(input int m, input logic rd, cs_n, bit_four);
		logic [1:0] ack, ea;
		logic [35:0] r;
		logic ok, full;
		logic [3:0] eo;
		logic [31:0] ed, msk, x, wd;
		time ta;
		int n0;
		@(negedge clk);
		n0 = nreq;
		rv = $urandom;
		wd = $urandom;
		x = $urandom;
		if (m == 0)
			low_address_bit = x[4];
		u_host.run(rd, cs_n, bit_four, x[3:1], wd, 30, ack, r, ok, ta);
		full = (m == 2) && bit_four;
		ea = full ? 2'b00 : (m == 0) ? 2'b10 : 2'b01;
		eo = full ? 4'hF : (m == 0) ? 4'h8 : 4'hC;
		ed = full ? rv : (m == 0) ? {rv[7:0], 24'h0} : {rv[15:0], 16'h0};
		msk = {{8{eo[3]}}, {8{eo[2]}}, {8{eo[1]}}, {8{eo[0]}}};
		cmp_f({1'b0, ok}, {1'b0, !cs_n});
		cmp_f(2'(nreq - n0), {1'b0, !cs_n});
		if (cs_n) begin
			cmp_f(ack, 2'b11);
			return;
		end
		cmp_f(ack, ea);
		cmp_d(80'(sel_r), 80'({bit_four, x[3:1], low_address_bit}));
		cmp_f({1'b0, wr_r}, {1'b0, !rd});
		cmp_f({1'b0, ta > rdy_t}, 2'b01);
		if (rd) begin
			cmp_d(80'(r[35:32]), 80'(eo));
			cmp_d(80'(r[31:0] & msk), 80'(ed));
		end else begin
			cmp_d(80'(wd_r), 80'(wd));
		end
	endtask

	initial begin
		void'($urandom(32'h385B));
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		fp_wr_en = 1'b1;
		fp_wr_sel = 4'h3;
		fp_wr_data = 80'({$urandom, $urandom, $urandom});
		@(negedge clk);
		fp_wr_en = 1'b0;
		fp_rd_sel = 4'h3;
		@(negedge clk);
		cmp_d(fp_rd_data, fp_wr_data);
		for (int m = 2; m >= 0; m--) begin
			width_strap_n = (m != 0);
			low_address_bit = (m == 2);
			rst = 1'b1;
			repeat (10) @(negedge clk);
			rst = 1'b0;
			repeat (4) @(negedge clk);
			cmp_f(bus_mode, 2'(m));
			fp_check();
			for (int k = 0; k < 8; k++)
				bus(m, k[0], 1'b0, k[1]);
			bus(m, 1'b1, 1'b1, 1'b1);
		end
		report_and_stop();
	end

	// About 700 cycles are expected; the limit allows over fifty times that.
	initial begin
		#160000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
